// *** pkg/sat_pkg.sv ***
/*
 * Constants and carrier types for the synchronous adapter timeout and gating block.
 * Assumes a host that reaches the block by byte-wide I/O reads and writes.
 */
package sat_pkg;
    localparam logic [9:0] ADDR_STATUS_PRI  = 10'h3a0;
    localparam logic [9:0] ADDR_GATING_PRI  = 10'h3a1;
    localparam logic [9:0] ADDR_CLKWRAP_PRI = 10'h3a2;
    localparam logic [9:0] ADDR_STATUS_ALT  = 10'h380;
    localparam logic [9:0] ADDR_GATING_ALT  = 10'h381;
    localparam logic [9:0] ADDR_CLKWRAP_ALT = 10'h382;
    localparam logic [9:0] ADDR_TIMER_CTL   = 10'h3a7;
    localparam logic [9:0] ADDR_CNT0        = 10'h3a4;
    localparam logic [9:0] ADDR_CNT1        = 10'h3a5;
    localparam logic [9:0] ADDR_CNT2        = 10'h3a6;
    localparam logic [9:0] ALT_OFFSET       = 10'h020;
    // Port A bit positions.
    localparam int A_TXCLK = 2;
    localparam int A_RXCLK = 3;
    localparam int A_TRANSMITTER_READY = 4;
    localparam int A_TMR2  = 6;
    localparam int A_TMR1  = 7;
    // Port B bit positions.
    localparam int B_SCRST = 4;
    localparam int B_GATE2 = 5;
    localparam int B_GATE1 = 6;
    localparam int B_IRQ4G = 7;
    // Port C bit positions.
    localparam int C_INTCLK = 0;
    localparam int C_EXTCLK = 1;
    localparam int C_WRAP   = 2;
    localparam int C_IRQDIS = 3;
    localparam int C_RXD    = 4;
    localparam int C_TMR0   = 5;
    localparam int C_TESTN  = 6;
    localparam int C_TYPEN  = 7;
    localparam logic [7:0] GATING_RESET  = 8'h00;
    localparam logic [3:0] CLKWRAP_RESET = 4'h8;
    localparam logic       ADAPTER_TYPE  = 1'b0;
    localparam logic [1:0] SEL_ILLEGAL   = 2'b11;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [3:0] BCD_NINE      = 4'h9;

    typedef enum logic [1:0] {
        SAT_RL_LATCH = 2'b00,
        SAT_RL_LSB   = 2'b01,
        SAT_RL_MSB   = 2'b10,
        SAT_RL_BOTH  = 2'b11
    } sat_rl_t;

    typedef struct packed {
        logic [1:0] counter_select;
        sat_rl_t    access_select;
        logic [2:0] count_mode;
        logic       bcd;
    } sat_ctl_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } sat_io_t;
endpackage

// *** logic/sat_top.sv ***
/*
 * Gating ports and inactivity timeout counters of a synchronous adapter.
 * Assumes I/O strobes are single-cycle and synchronous to clk; serial controller is outside.
 */
`timescale 1ns/10ps
//
// Overview of operation
// - Counter zero is not used for timeouts; only counters one and two time out.
// - Counters one and two raise level four interrupt at terminal count.
// - Control word decodes select, read/load, mode and decimal fields.
// - Select codes 00, 01, 10 address counters; 11 is illegal, ignored.
// - Read/load: 00 latch, 10 high only, 01 low only, 11 low then high.
// - Port A shows clock activity, transmitter ready and timer outputs.
// - Port B drives controller reset, timer gates and interrupt routing gate.
// - Port C outputs gate clocks and wrap; inputs show receive data, timer 0.
// - Port C bit written 0 enables timer, level six and level three interrupts.
// - Port C inputs read 0 for test indicate and for adapter type.
// - Alternate configuration decodes the three ports at 380, 381, 382.
// - Counters advance at half the system clock.
// - Timer 1 output on port A bit 7, timer 2 on bit 6.
// - Decimal select: 0 binary sixteen bit, 1 four decade decimal.
module sat_top
    import sat_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire sat_pkg::sat_io_t io,
    input  wire logic             alt_select,
    input  wire logic             tx_clk_in,
    input  wire logic             rx_clk_in,
    input  wire logic             transmitter_ready,
    input  wire logic             receiver_ready,
    input  wire logic             irq6_src,
    input  wire logic             rx_data_in,
    input  wire logic             timer0_out,
    input  wire logic             test_indicate_b,
    output logic [7:0]            rdata_ff,
    output logic                  sc_reset_ff,
    output logic                  int_clk_gate_ff,
    output logic                  ext_clk_gate_ff,
    output logic                  wrap_ff,
    output logic                  irq4_ff,
    output logic                  irq3_ff,
    output logic                  irq6_ff
);
    import sat_pkg::*;

    logic [7:0]  gating_ff;
    logic [3:0]  clkwrap_ff;
    logic        half_ff;
    sat_ctl_t    ctl_ff [1:2];
    logic [15:0] count_ff [1:2];
    logic [15:0] latch_ff [1:2];
    logic        latched_ff [1:2];
    logic        hi_next_ff [1:2];
    logic        rd_hi_ff [1:2];
    logic        out_ff [1:2];
    logic        armed_ff [1:2];
    logic [7:0]  lo_hold_ff [1:2];
    logic        alt_cfg_ff;
    logic [15:0] view_w [1:2];
    logic [9:0]  a_base;
    logic        hit_a;
    logic        hit_b;
    logic        hit_c;
    logic        hit_ctl;
    sat_ctl_t    wctl;

    // Alternate strap is sampled by a clocked process after reset release.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alt_cfg_ff <= 1'b0;
        end else begin
            alt_cfg_ff <= alt_select;
        end
    end

    // Port address decode for primary or alternate placement.
    always_comb begin
        a_base  = alt_cfg_ff ? ADDR_STATUS_ALT : ADDR_STATUS_PRI;
        hit_a   = io.addr == a_base;
        hit_b   = io.addr == (alt_cfg_ff ? ADDR_GATING_ALT : ADDR_GATING_PRI);
        hit_c   = io.addr == (alt_cfg_ff ? ADDR_CLKWRAP_ALT : ADDR_CLKWRAP_PRI);
        hit_ctl = io.addr == ADDR_TIMER_CTL;
        wctl    = sat_ctl_t'(io.wdata);
    end

    // Output ports B and C hold their written values.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gating_ff  <= GATING_RESET;
            clkwrap_ff <= CLKWRAP_RESET;
        end else begin
            if (io.wr && hit_b) begin
                gating_ff <= io.wdata;
            end
            if (io.wr && hit_c) begin
                clkwrap_ff <= io.wdata[3:0];
            end
        end
    end

    // Counters advance on every other system clock.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_ff <= 1'b0;
        end else begin
            half_ff <= ~half_ff;
        end
    end

    // Counter one and two programming and counting; counter zero lives elsewhere.
    for (genvar n = 1; n <= 2; n++) begin : g_cnt
        logic        gate;
        logic        wr_cnt;
        logic        rd_cnt;
        logic        zero;
        logic [15:0] dec;
        logic [15:0] load;
        assign gate   = (n == 1) ? gating_ff[B_GATE1] : gating_ff[B_GATE2];
        assign wr_cnt = io.wr && io.addr == ((n == 1) ? ADDR_CNT1 : ADDR_CNT2);
        assign rd_cnt = io.rd && io.addr == ((n == 1) ? ADDR_CNT1 : ADDR_CNT2);
        assign zero   = count_ff[n] == CNT_ONE;
        // Readback sees the latched snapshot while one is pending.
        assign view_w[n] = latched_ff[n] ? latch_ff[n] : count_ff[n];

        // Decrement, with a decade borrow chain in decimal mode.
        always_comb begin
            dec = count_ff[n] - CNT_ONE;
            if (ctl_ff[n].bcd) begin
                dec = count_ff[n];
                for (int d = 0; d < 4; d++) begin
                    if (count_ff[n][4*d +: 4] != 4'h0) begin
                        dec[4*d +: 4] = count_ff[n][4*d +: 4] - 4'h1;
                        break;
                    end
                    dec[4*d +: 4] = BCD_NINE;
                end
            end
        end

        // Byte staging for the selected load format.
        always_comb begin
            load = {io.wdata, io.wdata};
            unique case (ctl_ff[n].access_select)
                SAT_RL_LSB:  load = {8'h00, io.wdata};
                SAT_RL_MSB:  load = {io.wdata, 8'h00};
                SAT_RL_BOTH: load = {io.wdata, lo_hold_ff[n]};
                SAT_RL_LATCH: load = count_ff[n];
            endcase
        end

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                ctl_ff[n]     <= '0;
                count_ff[n]   <= '0;
                latch_ff[n]   <= '0;
                latched_ff[n] <= 1'b0;
                hi_next_ff[n] <= 1'b0;
                rd_hi_ff[n]   <= 1'b0;
                out_ff[n]     <= 1'b0;
                armed_ff[n]   <= 1'b0;
                lo_hold_ff[n] <= 8'h00;
            end else begin
                // Select code 11 is ignored, as is counter 0.
                if (io.wr && hit_ctl && wctl.counter_select == 2'(n)) begin
                    if (wctl.access_select == SAT_RL_LATCH) begin
                        latch_ff[n]   <= count_ff[n];
                        latched_ff[n] <= 1'b1;
                        rd_hi_ff[n]   <= 1'b0;
                    end else begin
                        ctl_ff[n]     <= wctl;
                        hi_next_ff[n] <= 1'b0;
                        rd_hi_ff[n]   <= 1'b0;
                        out_ff[n]     <= 1'b0;
                        armed_ff[n]   <= 1'b0;
                    end
                end else if (wr_cnt) begin
                    if (ctl_ff[n].access_select == SAT_RL_BOTH && !hi_next_ff[n]) begin
                        lo_hold_ff[n] <= io.wdata;
                        hi_next_ff[n] <= 1'b1;
                        out_ff[n]     <= 1'b0;
                        armed_ff[n]   <= 1'b0;
                    end else begin
                        count_ff[n]   <= load;
                        hi_next_ff[n] <= 1'b0;
                        out_ff[n]     <= 1'b0;
                        armed_ff[n]   <= 1'b1;
                    end
                end else if (half_ff && gate && armed_ff[n]) begin
                    count_ff[n] <= dec;
                    if (zero) begin
                        out_ff[n]   <= 1'b1;
                        armed_ff[n] <= 1'b0;
                    end
                end
                if (rd_cnt) begin
                    if (ctl_ff[n].access_select == SAT_RL_BOTH) begin
                        rd_hi_ff[n] <= ~rd_hi_ff[n];
                    end
                    if (ctl_ff[n].access_select != SAT_RL_BOTH || rd_hi_ff[n]) begin
                        latched_ff[n] <= 1'b0;
                    end
                end
            end
        end
    end

    // Read data mux for ports and counter readback.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else if (io.rd) begin
            rdata_ff <= 8'h00;
            if (hit_a) begin
                rdata_ff[A_TXCLK] <= tx_clk_in;
                rdata_ff[A_RXCLK] <= rx_clk_in;
                rdata_ff[A_TRANSMITTER_READY] <= transmitter_ready;
                rdata_ff[A_TMR2]  <= out_ff[2];
                rdata_ff[A_TMR1]  <= out_ff[1];
            end else if (hit_b) begin
                rdata_ff <= gating_ff;
            end else if (hit_c) begin
                rdata_ff[3:0]     <= clkwrap_ff;
                rdata_ff[C_RXD]   <= rx_data_in;
                rdata_ff[C_TMR0]  <= timer0_out;
                rdata_ff[C_TESTN] <= test_indicate_b;
                rdata_ff[C_TYPEN] <= ADAPTER_TYPE;
            end else begin
                for (int k = 1; k <= 2; k++) begin
                    if (io.addr == ((k == 1) ? ADDR_CNT1 : ADDR_CNT2)) begin
                        unique case (ctl_ff[k].access_select)
                            SAT_RL_MSB:  rdata_ff <= view_w[k][15:8];
                            SAT_RL_BOTH: rdata_ff <= rd_hi_ff[k] ? view_w[k][15:8] : view_w[k][7:0];
                            default:     rdata_ff <= view_w[k][7:0];
                        endcase
                    end
                end
            end
        end
    end

    // Outputs and gated interrupt requests.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sc_reset_ff     <= 1'b0;
            int_clk_gate_ff <= 1'b0;
            ext_clk_gate_ff <= 1'b0;
            wrap_ff         <= 1'b0;
            irq4_ff         <= 1'b0;
            irq3_ff         <= 1'b0;
            irq6_ff         <= 1'b0;
        end else begin
            sc_reset_ff     <= gating_ff[B_SCRST];
            int_clk_gate_ff <= clkwrap_ff[C_INTCLK];
            ext_clk_gate_ff <= clkwrap_ff[C_EXTCLK];
            wrap_ff         <= clkwrap_ff[C_WRAP];
            irq4_ff <= transmitter_ready | (!clkwrap_ff[C_IRQDIS] && gating_ff[B_IRQ4G]
                       && (out_ff[1] | out_ff[2]));
            irq3_ff <= receiver_ready && !clkwrap_ff[C_IRQDIS];
            irq6_ff <= irq6_src && !clkwrap_ff[C_IRQDIS];
        end
    end

    // A written terminal count gives a low output at once.
    property p_load_low;
        @(posedge clk) disable iff (!rst_b)
        (io.wr && io.addr == ADDR_CNT1 && ctl_ff[1].access_select != SAT_RL_BOTH)
            |=> !out_ff[1];
    endproperty
    a_load_low: assert property (p_load_low) else $error("timer 1 not low after load");

    property p_timeout_irq;
        @(posedge clk) disable iff (!rst_b)
        ($rose(out_ff[2]) && gating_ff[B_IRQ4G] && !clkwrap_ff[C_IRQDIS]) |=> irq4_ff;
    endproperty
    a_timeout_irq: assert property (p_timeout_irq) else $error("no level 4 on timeout");

    property p_irq_block;
        @(posedge clk) disable iff (!rst_b)
        clkwrap_ff[C_IRQDIS] |=> !irq3_ff;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("level 3 not blocked");

    property p_half_rate;
        @(posedge clk) disable iff (!rst_b)
        (count_ff[1] != $past(count_ff[1]) && !$past(io.wr) && !io.wr)
            |=> count_ff[1] == $past(count_ff[1]);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("counter ran at full rate");

    property p_gate_hold;
        @(posedge clk) disable iff (!rst_b)
        (!gating_ff[B_GATE2] && !io.wr) |=> $stable(count_ff[2]);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("counter 2 ran ungated");

    property p_illegal_sel;
        @(posedge clk) disable iff (!rst_b)
        (io.wr && io.addr == ADDR_TIMER_CTL && io.wdata[7:6] == SEL_ILLEGAL)
            |=> $stable(ctl_ff[1]) && $stable(ctl_ff[2]);
    endproperty
    a_illegal_sel: assert property (p_illegal_sel) else $error("illegal select accepted");

    property p_type_bit;
        @(posedge clk) disable iff (!rst_b)
        (io.rd && hit_c) |=> rdata_ff[C_TYPEN] == ADAPTER_TYPE;
    endproperty
    a_type_bit: assert property (p_type_bit) else $error("adapter type bit wrong");

    property p_port_b;
        @(posedge clk) disable iff (!rst_b)
        (io.wr && hit_b) |=> ##1 sc_reset_ff == $past(io.wdata[B_SCRST], 2);
    endproperty
    a_port_b: assert property (p_port_b) else $error("controller reset not driven");
endmodule

// *** verif/sat_host.sv ***
/*
 * Host processor model: issues byte-wide I/O reads and writes and loads counters.
 * Assumes the adapter takes a strobe at the first rising clock edge that sees it.
 */
`timescale 1ns/10ps
module sat_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata_ff,
    output sat_pkg::sat_io_t io
);
    import sat_pkg::*;
    initial io = '0;

    // One write: raised after an edge, taken at the next; the bus then shows inverted junk.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        io <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // One read: data is taken once the taking edge's updates have landed.
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        io <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        io <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        d = rdata_ff;
    endtask

    // Selects a counter with a load access in mode 0, then loads the bytes it asked for.
    task automatic load(input logic [7:0] ctl, input logic [9:0] a, input logic [15:0] v);
        wr(ADDR_TIMER_CTL, ctl);
        if (ctl[5:4] != 2'b10) wr(a, v[7:0]);
        if (ctl[5:4] != 2'b01) wr(a, v[15:8]);
    endtask
endmodule

// *** verif/tb.sv ***
/*
 * Self-checking testbench for the adapter gating ports and timeout counters.
 * Assumes the host model in sat_host drives every I/O request.
 */
`timescale 1ns/10ps
module tb;
    import sat_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, alt_select = 1'b0;
    logic       tx_clk_in = 1'b0, rx_clk_in = 1'b0, transmitter_ready = 1'b0;
    logic       receiver_ready = 1'b0, irq6_src = 1'b0, rx_data_in = 1'b1;
    logic       timer0_out = 1'b0, test_indicate_b = 1'b1;
    sat_io_t    io;
    logic [7:0] rdata_ff, d;
    logic       sc_reset_ff, int_clk_gate_ff, ext_clk_gate_ff, wrap_ff;
    logic       irq4_ff, irq3_ff, irq6_ff;
    int         mismatches = 0, total_checks = 0, n;

    // Clock at 100 MHz.
    always #5 clk = ~clk;

    sat_host host (.clk(clk), .rdata_ff(rdata_ff), .io(io));
    sat_top dut (.clk(clk), .rst_b(rst_b), .io(io), .alt_select(alt_select),
        .tx_clk_in(tx_clk_in), .rx_clk_in(rx_clk_in), .transmitter_ready(transmitter_ready),
        .receiver_ready(receiver_ready), .irq6_src(irq6_src), .rx_data_in(rx_data_in),
        .timer0_out(timer0_out), .test_indicate_b(test_indicate_b), .rdata_ff(rdata_ff),
        .sc_reset_ff(sc_reset_ff), .int_clk_gate_ff(int_clk_gate_ff),
        .ext_clk_gate_ff(ext_clk_gate_ff), .wrap_ff(wrap_ff), .irq4_ff(irq4_ff),
        .irq3_ff(irq3_ff), .irq6_ff(irq6_ff));

    // Compares one value and counts the result.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s: got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Reset state of pins and ports; port C inputs read back with interrupts blocked.
    task automatic t_reset();
        check({sc_reset_ff, int_clk_gate_ff, ext_clk_gate_ff, wrap_ff, irq4_ff, irq3_ff,
               irq6_ff}, 16'h0000, "pins at reset");
        host.rd(ADDR_GATING_PRI, d);
        check(d, 16'h0000, "port B reset");
        host.rd(ADDR_CLKWRAP_PRI, d);
        check(d, 16'h0058, "port C reset");
    endtask

    // Port A shows clock activity and transmitter ready; writes to it do nothing.
    task automatic t_porta();
        tx_clk_in <= 1'b1;
        transmitter_ready <= 1'b1;
        host.wr(ADDR_STATUS_PRI, 8'hff);
        host.rd(ADDR_STATUS_PRI, d);
        check(d & 8'h1c, 16'h0014, "port A tx side");
        check(irq4_ff, 16'h0001, "tx ready on level 4");
        tx_clk_in <= 1'b0;
        rx_clk_in <= 1'b1;
        transmitter_ready <= 1'b0;
        host.rd(ADDR_STATUS_PRI, d);
        check(d & 8'h1c, 16'h0008, "port A rx side");
        rx_clk_in <= 1'b0;
    endtask

    // Port B drives the serial controller reset and reads back.
    task automatic t_portb();
        host.wr(ADDR_GATING_PRI, 8'h10);
        settle(2);
        check(sc_reset_ff, 16'h0001, "controller reset high");
        host.rd(ADDR_GATING_PRI, d);
        check(d, 16'h0010, "port B readback");
        host.wr(ADDR_GATING_PRI, 8'h00);
        settle(2);
        check(sc_reset_ff, 16'h0000, "controller reset low");
    endtask

    // Port C clock gates, wrap, inputs and the level 3 and 6 interrupt block.
    task automatic t_portc();
        test_indicate_b <= 1'b0;
        timer0_out <= 1'b1;
        rx_data_in <= 1'b0;
        receiver_ready <= 1'b1;
        irq6_src <= 1'b1;
        host.wr(ADDR_CLKWRAP_PRI, 8'h07);
        settle(2);
        check({int_clk_gate_ff, ext_clk_gate_ff, wrap_ff}, 16'h0007, "gates");
        check({irq3_ff, irq6_ff}, 16'h0003, "enabled irqs");
        host.rd(ADDR_CLKWRAP_PRI, d);
        check(d, 16'h0027, "port C inputs");
        host.wr(ADDR_CLKWRAP_PRI, 8'h08);
        settle(2);
        check({irq3_ff, irq6_ff}, 16'h0000, "blocked irqs");
        receiver_ready <= 1'b0;
        irq6_src <= 1'b0;
        test_indicate_b <= 1'b1;
    endtask

    // Times a gated count to level 4, then reads the timer bit on port A.
    task automatic t_timer(input logic [7:0] b, input logic [7:0] ctl, input logic [9:0] a,
                           input logic [15:0] v, input int lo, input int hi, input int bit_a);
        host.wr(ADDR_CLKWRAP_PRI, 8'h00);
        host.wr(ADDR_GATING_PRI, b);
        host.load(ctl, a, v);
        host.rd(ADDR_STATUS_PRI, d);
        check(d[bit_a], 16'h0000, "out low after load");
        n = 0;
        while (irq4_ff !== 1'b1 && n < 40) begin
            settle(1);
            n++;
        end
        check(n >= lo && n <= hi, 16'h0001, "half rate timeout");
        host.rd(ADDR_STATUS_PRI, d);
        check(d[bit_a], 16'h0001, "timer bit on port A");
        host.wr(ADDR_CLKWRAP_PRI, 8'h08);
        settle(2);
        check(irq4_ff, 16'h0000, "level 4 blocked");
        // A fresh control word drops the output so the next timeout starts clean.
        host.wr(ADDR_TIMER_CTL, ctl);
        host.rd(ADDR_STATUS_PRI, d);
        check(d[bit_a], 16'h0000, "out low after new control word");
    endtask

    // Latch, high-only load and ignored control words on counter 1.
    task automatic t_latch();
        host.wr(ADDR_GATING_PRI, 8'h00);
        host.load(8'h70, ADDR_CNT1, 16'h1234);
        host.wr(ADDR_TIMER_CTL, 8'h40);
        host.rd(ADDR_CNT1, d);
        check(d, 16'h0034, "latched low");
        host.rd(ADDR_CNT1, d);
        check(d, 16'h0012, "latched high");
        host.load(8'h60, ADDR_CNT1, 16'h0200);
        host.wr(ADDR_TIMER_CTL, 8'hd0);
        host.wr(ADDR_TIMER_CTL, 8'h10);
        host.rd(ADDR_CNT1, d);
        check(d, 16'h0002, "high only, others ignored");
    endtask

    // Alternate placement moves the three ports.
    task automatic t_alt();
        alt_select <= 1'b1;
        tx_clk_in <= 1'b1;
        host.wr(ADDR_GATING_ALT, 8'h20);
        host.rd(ADDR_GATING_ALT, d);
        check(d, 16'h0020, "alt port B");
        host.rd(ADDR_GATING_PRI, d);
        check(d, 16'h0000, "primary unmapped");
        host.rd(ADDR_CLKWRAP_ALT, d);
        check(d[3:0], 16'h0008, "alt port C");
        host.rd(ADDR_STATUS_ALT, d);
        check(d[2], 16'h0001, "alt port A");
        alt_select <= 1'b0;
        tx_clk_in <= 1'b0;
    endtask

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        settle(1);
        t_reset();
        t_porta();
        t_portb();
        t_portc();
        t_timer(8'hc0, 8'h70, ADDR_CNT1, 16'h0005, 5, 12, A_TMR1);
        t_timer(8'ha0, 8'h90, ADDR_CNT2, 16'h0003, 2, 9, A_TMR2);
        t_timer(8'hc0, 8'h71, ADDR_CNT1, 16'h0010, 16, 21, A_TMR1);
        t_latch();
        t_alt();
        final_report();
    end

    // Watchdog against a hang.
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule
